// ==== shared/bidir_flag_pkg.sv ====
// Shared constants and types for the bidirectional queue flag logic
package bidir_flag_pkg;

	// Queue depth options
	localparam int DEPTH_SMALL  = 16384;
	localparam int DEPTH_MEDIUM = 32768;
	localparam int DEPTH_LARGE  = 65536;

	// Data word width and fill counter width
	localparam int WORD_W = 36;
	localparam int CNT_W  = 17;

	// Staging buffer depth in front of the queue 1 memory port
	localparam int STAGE_DEPTH = 32;

	// Clock period and skew limits in ns
	localparam int CLK_PERIOD_NS         = 10;
	localparam int FIRST_SKEW_LIMIT_NS   = 5;
	localparam int SECOND_SKEW_LIMIT_NS  = 7;

	// Skew limits in core cycles, rounded up, at least one
	localparam int FIRST_SKEW_CYC_RAW  =
		(FIRST_SKEW_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECOND_SKEW_CYC_RAW =
		(SECOND_SKEW_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] FIRST_SKEW_CYC  =
		8'(FIRST_SKEW_CYC_RAW < 1 ? 1 : FIRST_SKEW_CYC_RAW);
	localparam logic [7:0] SECOND_SKEW_CYC =
		8'(SECOND_SKEW_CYC_RAW < 1 ? 1 : SECOND_SKEW_CYC_RAW);

	// Port operation decode levels
	localparam logic A_DIR_WRITE = 1'b1;
	localparam logic B_DIR_READ  = 1'b1;

	// Flag reset values
	localparam logic FULL_RST   = 1'b1;
	localparam logic READY_RST  = 1'b0;
	localparam logic AEMPTY_RST = 1'b0;
	localparam logic AFULL_RST  = 1'b1;

	// Control pins of one port
	typedef struct packed {
		logic chip_select_n;
		logic direction;
		logic mail_select;
		logic enable;
	} port_ctl_t;

	// Flag outputs of one port
	typedef struct packed {
		logic full_flag;
		logic input_ready;
		logic almost_empty;
		logic almost_full;
	} port_flags_t;

endpackage : bidir_flag_pkg

// ==== src/bidir_fifo_flag_sync.sv ====
// Flag synchronization for two opposite queues, with a staging buffer
// Summary of operation
// - In fall-through mode port A input-ready rises on the next A edge after a B read frees queue 1, one A edge later inside the first skew limit.
// - In standard mode port A full flag rises on the next A edge after a B read frees queue 1, one A edge later inside the first skew limit.
// - In fall-through mode port B input-ready rises on the next B edge after an A read frees queue 2, one B edge later inside the first skew limit.
// - In standard mode port B full flag rises on the next B edge after an A read frees queue 2, one B edge later inside the first skew limit.
// - Port B almost-empty rises on the next B edge after an A write lifts queue 1 above its offset, one B edge later inside the second skew limit.
// - Port A almost-empty rises on an A edge after a B write lifts queue 2 from its offset to one more, one A edge later inside the second skew limit.
// - Port A almost-full rises on an A edge after a B read lowers queue 1, one A edge later inside the second skew limit.
// - Port B almost-full rises on a B edge after an A read lowers queue 2, one B edge later inside the second skew limit.
// - Queue depth is one of three sizes; the full and almost-full thresholds are taken against it, the almost-empty ones against zero.
// - After a read the almost-full flag needs two edges of its own port clock to show the new fill.
`timescale 1ns/1ps

// Parameterised buffer with registered output stage
module stage_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_ce,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} fifo_st_t;

	fifo_st_t st_q;
	fifo_st_t st_d;
	logic     push;
	logic     pop;

	// Handshakes on both sides
	assign o_in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
	assign push        = i_in_valid && o_in_ready;
	assign pop         = (st_q.cnt != '0) && (!st_q.ov || i_out_ready);
	assign o_out_valid = st_q.ov;
	assign o_out_data  = st_q.od;

	// Next state: store, move into output stage, count
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr] = i_in_data;
			st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
		end
		if (pop) begin
			st_d.od = st_q.mem[st_q.rd];
			st_d.ov = 1'b1;
			st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
		end else if (i_out_ready) begin
			st_d.ov = 1'b0;
		end
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register, frozen while clock enable is low
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= '0;
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end
endmodule : stage_fifo

// Flag logic for both ports
module bidir_fifo_flag_sync #(
	parameter int DEPTH = bidir_flag_pkg::DEPTH_LARGE
) (
	input  wire logic                              i_core_clk,
	input  wire logic                              i_rstn,
	input  wire logic                              i_ce,
	input  wire logic                              i_port_a_clock,
	input  wire logic                              i_port_b_clock,
	input  wire bidir_flag_pkg::port_ctl_t         i_a_ctl,
	input  wire bidir_flag_pkg::port_ctl_t         i_b_ctl,
	input  wire logic                              i_fall_through_select,
	input  wire logic [bidir_flag_pkg::WORD_W-1:0] i_a_data,
	input  wire logic [bidir_flag_pkg::CNT_W-1:0]  i_q1_empty_offset,
	input  wire logic [bidir_flag_pkg::CNT_W-1:0]  i_q1_full_offset,
	input  wire logic [bidir_flag_pkg::CNT_W-1:0]  i_queue2_empty_offset,
	input  wire logic [bidir_flag_pkg::CNT_W-1:0]  i_q2_full_offset,
	output bidir_flag_pkg::port_flags_t            o_a_flags,
	output bidir_flag_pkg::port_flags_t            o_b_flags,
	output logic                                   o_q1_mem_valid,
	output logic      [bidir_flag_pkg::WORD_W-1:0] o_q1_mem_data,
	input  wire logic                              i_q1_mem_ready
);
	localparam int CW = bidir_flag_pkg::CNT_W;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	typedef struct packed {
		logic                 port_a_clock;
		logic                 port_b_clock;
		logic [7:0]           since_a;
		logic [7:0]           since_b;
		logic [CW-1:0]        q1_wr;
		logic [CW-1:0]        q1_rd;
		logic [CW-1:0]        q2_wr;
		logic [CW-1:0]        q2_rd;
		logic [CW-1:0]        q1_wr_prev;
		logic [CW-1:0]        q1_rd_prev;
		logic [CW-1:0]        q2_wr_prev;
		logic [CW-1:0]        q2_rd_prev;
		logic [CW-1:0]        a_q1_rd_seen;
		logic [CW-1:0]        b_q2_rd_seen;
		bidir_flag_pkg::port_flags_t a_fl;
		bidir_flag_pkg::port_flags_t b_fl;
	} top_st_t;

	top_st_t st_q;
	top_st_t st_d;
	logic    a_edge;
	logic    b_edge;
	logic    a_sel;
	logic    b_sel;
	logic    a_wr;
	logic    a_rd;
	logic    b_wr;
	logic    b_rd;
	logic    stage_ready;

	// Latest value once the other port edge is older than the limit
	function automatic logic [CW-1:0] seen(input logic [CW-1:0] cur,
		input logic [CW-1:0] prev, input logic [7:0] since,
		input logic [7:0] lim);
		seen = (since >= lim) ? cur : prev;
	endfunction : seen

	// Words held for a pair of pointers
	function automatic logic [CW-1:0] fill(input logic [CW-1:0] wr,
		input logic [CW-1:0] rd);
		fill = wr - rd;
	endfunction : fill

	// Port clock edges and queue operations
	assign a_edge = i_port_a_clock && !st_q.port_a_clock;
	assign b_edge = i_port_b_clock && !st_q.port_b_clock;
	assign a_sel  = a_edge && !i_a_ctl.chip_select_n && i_a_ctl.enable
		&& !i_a_ctl.mail_select;
	assign b_sel  = b_edge && !i_b_ctl.chip_select_n && i_b_ctl.enable
		&& !i_b_ctl.mail_select;
	assign a_wr = a_sel && (i_a_ctl.direction == bidir_flag_pkg::A_DIR_WRITE)
		&& st_q.a_fl.full_flag && stage_ready;
	assign a_rd = a_sel && (i_a_ctl.direction != bidir_flag_pkg::A_DIR_WRITE)
		&& (st_q.q2_wr != st_q.q2_rd);
	assign b_rd = b_sel && (i_b_ctl.direction == bidir_flag_pkg::B_DIR_READ)
		&& (st_q.q1_wr != st_q.q1_rd);
	assign b_wr = b_sel && (i_b_ctl.direction != bidir_flag_pkg::B_DIR_READ)
		&& st_q.b_fl.full_flag;

	// Words written at port A pass through the staging buffer
	stage_fifo #(
		.WIDTH (bidir_flag_pkg::WORD_W),
		.DEPTH (bidir_flag_pkg::STAGE_DEPTH)
	) u_stage (
		.i_core_clk  (i_core_clk),
		.i_rstn      (i_rstn),
		.i_ce        (i_ce),
		.i_in_valid  (a_wr),
		.i_in_data   (i_a_data),
		.o_in_ready  (stage_ready),
		.o_out_valid (o_q1_mem_valid),
		.o_out_data  (o_q1_mem_data),
		.i_out_ready (i_q1_mem_ready)
	);

	assign o_a_flags = st_q.a_fl;
	assign o_b_flags = st_q.b_fl;

	// Pointer, edge age and flag updates
	always_comb begin
		logic [CW-1:0] v;
		logic          room;
		v = '0;
		room = 1'b0;
		st_d = st_q;
		st_d.port_a_clock = i_port_a_clock;
		st_d.port_b_clock = i_port_b_clock;
		st_d.since_a = (st_q.since_a == 8'hFF) ? 8'hFF : st_q.since_a + 8'h01;
		st_d.since_b = (st_q.since_b == 8'hFF) ? 8'hFF : st_q.since_b + 8'h01;
		if (a_edge) begin
			st_d.since_a = 8'h01;
			st_d.q1_wr_prev = st_q.q1_wr;
			st_d.q2_rd_prev = st_q.q2_rd;
		end
		if (b_edge) begin
			st_d.since_b = 8'h01;
			st_d.q1_rd_prev = st_q.q1_rd;
			st_d.q2_wr_prev = st_q.q2_wr;
		end
		if (a_wr) st_d.q1_wr = st_q.q1_wr + 1'b1;
		if (a_rd) st_d.q2_rd = st_q.q2_rd + 1'b1;
		if (b_rd) st_d.q1_rd = st_q.q1_rd + 1'b1;
		if (b_wr) st_d.q2_wr = st_q.q2_wr + 1'b1;
		// Port A flags, taken on port A edges only
		if (a_edge) begin
			v = seen(st_q.q1_rd, st_q.q1_rd_prev, st_q.since_b,
				bidir_flag_pkg::FIRST_SKEW_CYC);
			room = fill(st_d.q1_wr, v) < DEPTH_C;
			st_d.a_fl.full_flag   = room;
			st_d.a_fl.input_ready = room && i_fall_through_select;
			v = seen(st_q.q2_wr, st_q.q2_wr_prev, st_q.since_b,
				bidir_flag_pkg::SECOND_SKEW_CYC);
			st_d.a_fl.almost_empty =
				fill(v, st_d.q2_rd) > i_queue2_empty_offset;
			st_d.a_q1_rd_seen = seen(st_q.q1_rd, st_q.q1_rd_prev,
				st_q.since_b, bidir_flag_pkg::SECOND_SKEW_CYC);
			st_d.a_fl.almost_full = fill(st_d.q1_wr, st_q.a_q1_rd_seen)
				<= DEPTH_C - (i_q1_full_offset + 1'b1);
		end
		// Port B flags, taken on port B edges only
		if (b_edge) begin
			v = seen(st_q.q2_rd, st_q.q2_rd_prev, st_q.since_a,
				bidir_flag_pkg::FIRST_SKEW_CYC);
			room = fill(st_d.q2_wr, v) < DEPTH_C;
			st_d.b_fl.full_flag   = room;
			st_d.b_fl.input_ready = room && i_fall_through_select;
			v = seen(st_q.q1_wr, st_q.q1_wr_prev, st_q.since_a,
				bidir_flag_pkg::SECOND_SKEW_CYC);
			st_d.b_fl.almost_empty =
				fill(v, st_d.q1_rd) > i_q1_empty_offset;
			st_d.b_q2_rd_seen = seen(st_q.q2_rd, st_q.q2_rd_prev,
				st_q.since_a, bidir_flag_pkg::SECOND_SKEW_CYC);
			st_d.b_fl.almost_full = fill(st_d.q2_wr, st_q.b_q2_rd_seen)
				<= DEPTH_C - (i_q2_full_offset + 1'b1);
		end
	end

	// State register, frozen while clock enable is low
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= '0;
			st_q.since_a <= 8'hFF;
			st_q.since_b <= 8'hFF;
			st_q.a_fl <= '{bidir_flag_pkg::FULL_RST,
				bidir_flag_pkg::READY_RST,
				bidir_flag_pkg::AEMPTY_RST, bidir_flag_pkg::AFULL_RST};
			st_q.b_fl <= '{bidir_flag_pkg::FULL_RST,
				bidir_flag_pkg::READY_RST,
				bidir_flag_pkg::AEMPTY_RST, bidir_flag_pkg::AFULL_RST};
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end
endmodule : bidir_fifo_flag_sync

// ==== verification/bidir_fifo_flag_sync_properties.sv ====
// Timing checks on the flag outputs of both ports
`timescale 1ns/1ps
module flag_sync_properties (
	input	wire logic				i_core_clk,
	input	wire logic				i_rstn,
	input	wire logic				i_ce,
	input	wire logic				i_port_a_clock,
	input	wire logic				i_port_b_clock,
	input	wire bidir_flag_pkg::port_ctl_t		i_a_ctl,
	input	wire bidir_flag_pkg::port_ctl_t		i_b_ctl,
	input	wire logic				i_fall_through_select,
	input	wire logic [16:0]			i_q1_full_offset,
	input	wire logic [16:0]			i_q2_full_offset,
	input	wire bidir_flag_pkg::port_flags_t	o_a_flags,
	input	wire bidir_flag_pkg::port_flags_t	o_b_flags
);
	logic	a_q, b_q, a_rise, b_rise;
	// Port clock levels of the last enabled cycle
	always_ff @(posedge i_core_clk or negedge i_rstn)
		if (!i_rstn) {a_q, b_q} <= 2'h0;
		else if (i_ce) {a_q, b_q} <= {i_port_a_clock, i_port_b_clock};
	assign a_rise = i_ce & i_port_a_clock & !a_q;
	assign b_rise = i_ce & i_port_b_clock & !b_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	// Queue reads taken at a port edge
	sequence b_rd; b_rise && i_b_ctl == 4'h5; endsequence
	sequence a_rd; a_rise && i_a_ctl == 4'h1; endsequence
	a_stand_port_a: assert property (!a_rise |=> $stable(o_a_flags))
		else $error("port A flags moved off an A edge");
	a_stand_port_b: assert property (!b_rise |=> $stable(o_b_flags))
		else $error("port B flags moved off a B edge");
	a_full_port_a: assert property (b_rd ##0 !o_a_flags.full_flag
		|-> ##[1:4] o_a_flags.full_flag) else $error("A full late");
	a_full_port_b: assert property (a_rd ##0 !o_b_flags.full_flag
		|-> ##[1:4] o_b_flags.full_flag) else $error("B full late");
	a_ready_port_a: assert property (b_rd ##0 !o_a_flags.input_ready
		&& i_fall_through_select |-> ##[1:4] o_a_flags.input_ready)
		else $error("A ready late");
	a_ready_port_b: assert property (a_rd ##0 !o_b_flags.input_ready
		&& i_fall_through_select |-> ##[1:4] o_b_flags.input_ready)
		else $error("B ready late");
	a_afull_port_a: assert property (b_rd ##0 !o_a_flags.full_flag
		&& i_q1_full_offset == 17'h0 |=> !o_a_flags.almost_full [*3]
		##[1:3] o_a_flags.almost_full) else $error("A almost full timing");
	a_afull_port_b: assert property (a_rd ##0 !o_b_flags.full_flag
		&& i_q2_full_offset == 17'h0 |=> !o_b_flags.almost_full [*3]
		##[1:3] o_b_flags.almost_full) else $error("B almost full timing");
	a_ready_std_mode: assert property (!i_fall_through_select [*4]
		|-> !o_a_flags.input_ready) else $error("ready in standard mode");
endmodule : flag_sync_properties

bind bidir_fifo_flag_sync flag_sync_properties u_props (.i_core_clk, .i_rstn,
	.i_ce, .i_port_a_clock, .i_port_b_clock, .i_a_ctl, .i_b_ctl,
	.i_fall_through_select, .i_q1_full_offset, .i_q2_full_offset,
	.o_a_flags, .o_b_flags);

// ==== verification/q1_sink_model.sv ====
// Memory-side sink for staged queue 1 words
`timescale 1ns/1ps
module q1_sink_model (
	input	wire logic		i_core_clk,
	input	wire logic [1:0]	i_mode,
	output	logic			o_ready
);
	logic [1:0]	cnt_q = 2'h0;
	// Mode 0 prompt, 1 stalls one cycle in four, 2 holds off
	always @(posedge i_core_clk) cnt_q <= cnt_q + 2'h1;
	assign o_ready = i_mode == 2'h0 || (i_mode == 2'h1 && cnt_q != 2'h3);
endmodule : q1_sink_model

// ==== verification/bidir_fifo_flag_sync_tb.sv ====
// Self-checking bench for the two-queue flag logic
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
	errors++; $display("mismatch %s exp %h seen %h", n, e, s); end end
module bidir_fifo_flag_sync_tb;
	localparam int D = bidir_flag_pkg::DEPTH_SMALL;
	bidir_flag_pkg::port_ctl_t	actl = 4'h9, bctl = 4'h9;
	bidir_flag_pkg::port_flags_t	af, bf;
	logic		clk = 1'b0, rstn = 1'b0, ca = 1'b0, cb = 1'b0;
	logic		fall_through_select = 1'b0, ce = 1'b1, mv, ready;
	logic [1:0]	mode = 2'h1;
	logic [15:0]	lfsr = 16'h0049;
	logic [35:0]	adata = 36'h0, md, w;
	logic [35:0]	exp_q[$];
	int		errors = 0, check_count = 0;
	bidir_fifo_flag_sync #(.DEPTH(D)) DUT (.i_core_clk(clk), .i_rstn(rstn),
		.i_ce(ce), .i_port_a_clock(ca), .i_port_b_clock(cb),
		.i_a_ctl(actl), .i_b_ctl(bctl), .i_fall_through_select(fall_through_select),
		.i_a_data(adata), .i_q1_empty_offset(17'h2),
		.i_q1_full_offset(17'h0), .i_queue2_empty_offset(17'h2),
		.i_q2_full_offset(17'h0), .o_a_flags(af), .o_b_flags(bf),
		.o_q1_mem_valid(mv), .o_q1_mem_data(md), .i_q1_mem_ready(ready));
	q1_sink_model sink (.i_core_clk(clk), .i_mode(mode), .o_ready(ready));
	initial forever #5 clk = ~clk;
	function automatic logic [15:0] next_lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : next_lfsr
	// One rising edge on both port clocks carrying the given operations
	task automatic op(input logic [3:0] a, input logic [3:0] b);
		@(posedge clk) #1;
		lfsr = next_lfsr(lfsr);
		{ca, cb, actl, bctl} = {2'h3, a, b};
		adata = {lfsr[3:0], lfsr, lfsr};
		if (a == 4'h5) exp_q.push_back(adata);
		@(posedge clk) #1;
		{ca, cb, actl, bctl} = {2'h0, 4'h9, 4'h9};
	endtask : op
	// B edge one core cycle before the A edge, A flags read just after it
	task automatic op_skew(input logic [3:0] a, b, ea);
		@(posedge clk) #1;
		{cb, bctl} = {1'b1, b};
		@(posedge clk) #1;
		{ca, cb, actl, bctl} = {2'h2, a, 4'h9};
		@(posedge clk) #1;
		{ca, actl} = {1'b0, 4'h9};
		`CHK("skew port A", ea, af)
	endtask : op_skew
	// Let both ports clock idle edges, then compare the flags
	task automatic chk_flags(input string n, input logic [3:0] ea, eb);
		repeat (3) op(4'h9, 4'h9);
		`CHK({n, " port A"}, ea, af)
		`CHK({n, " port B"}, eb, bf)
		$display("test %s done", n);
	endtask : chk_flags
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// Each staged word leaving the block is matched to the oldest note
	always @(posedge clk) if (mv === 1'b1 && ready && ce) begin
		w = exp_q.pop_front();
		`CHK("q1 word", w, md)
	end
	// Filling a queue takes about 330 us, so 400 us means a hang
	initial begin
		#400us;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rstn = 1'b1;
		chk_flags("reset", 4'h9, 4'h9);
		repeat (2) op(4'h5, 4'h1);
		op(4'h7, 4'h3);
		op(4'h4, 4'h0);
		chk_flags("below", 4'h9, 4'h9);
		op(4'h5, 4'h1);
		chk_flags("above", 4'hB, 4'hB);
		// Reads offered while the clock enable is low must be lost
		ce = 1'b0;
		op(4'h1, 4'h5);
		ce = 1'b1;
		chk_flags("frozen", 4'hB, 4'hB);
		repeat (3) op(4'h1, 4'h5);
		// Staging buffer overrun with the sink held off
		mode = 2'h2;
		repeat (36) op(4'h5, 4'h9);
		mode = 2'h0;
		repeat (40) @(posedge clk);
		`CHK("held", 3, exp_q.size())
		exp_q.delete();
		repeat (36) op(4'h9, 4'h5);
		mode = 2'h1;
		repeat (D) op(4'h5, 4'h1);
		chk_flags("full", 4'h2, 4'h2);
		op_skew(4'h1, 4'h5, 4'hA);
		chk_flags("freed", 4'hB, 4'hB);
		fall_through_select = 1'b1;
		op(4'h5, 4'h1);
		chk_flags("refill", 4'h2, 4'h2);
		op(4'h1, 4'h5);
		chk_flags("ready", 4'hF, 4'hF);
		`CHK("left", 0, exp_q.size())
		tally_and_finish();
	end
endmodule : bidir_fifo_flag_sync_tb
